// ===== rtl/nahif_pkg.sv
package nahif_pkg;
  // clock and derived timing counts
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PWR_WAIT_US   = 100;
  localparam int unsigned SETTLE_NS     = 100;
  localparam int unsigned BUSY_WAIT_NS  = 100;
  localparam int unsigned PWR_WAIT_CYC  = (PWR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] PWR_WAIT_CNT  = 16'(PWR_WAIT_CYC);
  localparam logic [15:0] SETTLE_CNT    = 16'(SETTLE_CYC);
  localparam logic [15:0] BUSY_WAIT_CNT = 16'(BUSY_WAIT_CYC);
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;

  // opcodes
  localparam logic [7:0] OPC_RESET     = 8'hFF;
  localparam logic [7:0] OPC_STATUS    = 8'h70;
  localparam logic [7:0] OPC_READ_MODE = 8'h00;
  localparam logic [7:0] OPC_READ_GO   = 8'h30;
  localparam logic [7:0] OPC_PROG      = 8'h80;
  localparam logic [7:0] OPC_PROG_GO   = 8'h10;

  // address layout: five cycles, row = block_bit[16:6] & page_bit[5:0]
  localparam logic [2:0] ADDR_LAST = 3'h4;
  localparam int unsigned PAGE_W   = 6;
  localparam int unsigned BLOCK_W  = 11;

  // bus cycle phases: strobe active in [STB_ON, STB_OFF)
  localparam logic [2:0] PH_STB_ON  = 3'h1;
  localparam logic [2:0] PH_STB_OFF = 3'h5;
  localparam logic [2:0] PH_LAST    = 3'h6;

  typedef enum logic [1:0] {
    CK_CMD  = 2'h0,
    CK_ADDR = 2'h1,
    CK_DIN  = 2'h2,
    CK_DOUT = 2'h3
  } nahif_ck_t;

  typedef enum logic [1:0] {
    OP_RESET  = 2'h0,
    OP_STATUS = 2'h1,
    OP_READ   = 2'h2,
    OP_PROG   = 2'h3
  } nahif_op_t;

  typedef enum logic [11:0] {
    S_IDLE   = 12'h001,
    S_PWR    = 12'h002,
    S_CMD1   = 12'h004,
    S_ADDR   = 12'h008,
    S_DIN    = 12'h010,
    S_CMD2   = 12'h020,
    S_BUSY   = 12'h040,
    S_RDMODE = 12'h080,
    S_DOUT   = 12'h100,
    S_STAT   = 12'h200,
    S_STATRD = 12'h400,
    S_WPSET  = 12'h800
  } nahif_st_t;
endpackage : nahif_pkg

// ===== rtl/nahif_cyc_if.sv
`timescale 1ns/1ps
interface nahif_cyc_if;
  import nahif_pkg::*;
  logic            req;
  nahif_ck_t       kind;
  logic [7:0]      wbyte;
  logic            sel;
  logic            done;
  logic [7:0]      rbyte;
  modport seq (output req, kind, wbyte, sel, input done, rbyte);
  modport eng (input req, kind, wbyte, sel, output done, rbyte);
endinterface : nahif_cyc_if

// ===== rtl/nahif_cycle.sv
`timescale 1ns/1ps
module nahif_cycle (
  input  wire logic        clk,
  input  wire logic        srst,
  nahif_cyc_if.eng         cyc,
  input  wire logic [7:0]  io_in,
  output logic      [7:0]  io_out,
  output logic             io_oe_n,
  output logic             chip_select_n,
  output logic             cmd_latch_en,
  output logic             addr_latch_en,
  output logic             write_strobe_n,
  output logic             read_strobe_n
);
  import nahif_pkg::*;

  logic [2:0]  ph_ff, nxt_ph;
  nahif_ck_t   kind_ff, nxt_kind;
  logic [7:0]  wbyte_ff, nxt_wbyte, rbyte_ff, nxt_rbyte;
  logic [7:0]  io_meta_ff, io_sync_ff;
  logic        done_ff, nxt_done, oe_n_ff, nxt_oe_n, ce_n_ff, nxt_ce_n;
  logic        cle_ff, nxt_cle, ale_ff, nxt_ale, we_n_ff, nxt_we_n, re_n_ff, nxt_re_n;
  logic        start, on, strobe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // phase sequencing; done blocks restart on the request being dropped
  always_comb begin
    start     = cyc.req && (ph_ff == 3'h0) && !done_ff;
    nxt_ph    = ph_ff;
    nxt_kind  = kind_ff;
    nxt_wbyte = wbyte_ff;
    if (start) begin
      nxt_ph    = 3'h1;
      nxt_kind  = cyc.kind;
      nxt_wbyte = cyc.wbyte;
    end else if (ph_ff != 3'h0) begin
      nxt_ph = (ph_ff == PH_LAST) ? 3'h0 : ph_ff + 3'h1;
    end
    on       = (nxt_ph != 3'h0);
    strobe   = (nxt_ph >= PH_STB_ON) && (nxt_ph < PH_STB_OFF);
    nxt_cle  = on && (nxt_kind == CK_CMD);
    nxt_ale  = on && (nxt_kind == CK_ADDR);
    nxt_we_n = !(strobe && (nxt_kind != CK_DOUT));
    nxt_re_n = !(strobe && (nxt_kind == CK_DOUT));
    nxt_oe_n = !(on && (nxt_kind != CK_DOUT));
    nxt_ce_n = !(cyc.sel || on);
    nxt_done = (ph_ff == PH_LAST);
    // sample the synced bus on the read strobe's rising edge
    nxt_rbyte = rbyte_ff;
    if ((nxt_ph == PH_STB_OFF) && (nxt_kind == CK_DOUT)) begin
      nxt_rbyte = io_sync_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ph_ff      <= 3'h0;
      kind_ff    <= CK_CMD;
      wbyte_ff   <= 8'h00;
      rbyte_ff   <= 8'h00;
      io_meta_ff <= 8'h00;
      io_sync_ff <= 8'h00;
      done_ff    <= 1'b0;
      oe_n_ff    <= 1'b1;
      ce_n_ff    <= 1'b1;
      cle_ff     <= 1'b0;
      ale_ff     <= 1'b0;
      we_n_ff    <= 1'b1;
      re_n_ff    <= 1'b1;
    end else begin
      ph_ff      <= nxt_ph;
      kind_ff    <= nxt_kind;
      wbyte_ff   <= nxt_wbyte;
      rbyte_ff   <= nxt_rbyte;
      io_meta_ff <= io_in;
      io_sync_ff <= io_meta_ff;
      done_ff    <= nxt_done;
      oe_n_ff    <= nxt_oe_n;
      ce_n_ff    <= nxt_ce_n;
      cle_ff     <= nxt_cle;
      ale_ff     <= nxt_ale;
      we_n_ff    <= nxt_we_n;
      re_n_ff    <= nxt_re_n;
    end
  end

  // pins straight from flops
  assign io_out         = wbyte_ff;
  assign io_oe_n        = oe_n_ff;
  assign chip_select_n  = ce_n_ff;
  assign cmd_latch_en   = cle_ff;
  assign addr_latch_en  = ale_ff;
  assign write_strobe_n = we_n_ff;
  assign read_strobe_n  = re_n_ff;
  assign cyc.done       = done_ff;
  assign cyc.rbyte      = rbyte_ff;

  a_cmd_latch: assert property ($rose(we_n_ff) && cle_ff |-> !ale_ff && !ce_n_ff && re_n_ff)
    else $error("command latched with bad control levels");
  a_data_drive: assert property ($rose(we_n_ff) && !cle_ff && !ale_ff |-> !ce_n_ff && re_n_ff
    && !oe_n_ff) else $error("data write without bus drive");
  a_read_low: assert property ($rose(re_n_ff) |-> $past(re_n_ff, 4) == 1'b0)
    else $error("read strobe low too short before sampling");
endmodule : nahif_cycle

// ===== rtl/nahif_ctrl.sv
`timescale 1ns/1ps
// Function
// - read mode command before data after enhanced status
// - slow read cycle samples at strobe rise
// - five address cycles, least significant first
// - column bit 12 set forces bits 11..8 zero
// - unused address bits low, full cycle count
// - protect change only when ready, then settle
// - wait ready and 100us before first reset
// - reset is the very first command
module nahif_ctrl (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 op_valid,
  input  wire nahif_pkg::nahif_op_t op_kind,
  input  wire logic [12:0]          op_col,
  input  wire logic [5:0]           op_page,
  input  wire logic [10:0]          op_block,
  input  wire logic [12:0]          op_len,
  input  wire logic                 protect_req,
  input  wire logic [7:0]           wr_byte,
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  output logic      [7:0]           rd_byte,
  output logic                      rd_valid,
  output logic                      op_ready,
  output logic                      op_done,
  output logic      [7:0]           op_status,
  input  wire logic [7:0]           io_in,
  output logic      [7:0]           io_out,
  output logic                      io_oe_n,
  output logic                      chip_select_n,
  output logic                      cmd_latch_en,
  output logic                      addr_latch_en,
  output logic                      write_strobe_n,
  output logic                      read_strobe_n,
  output logic                      write_protect_n,
  input  wire logic                 ready_busy_n
);
  import nahif_pkg::*;

  nahif_cyc_if cyc ();

  nahif_st_t   state_ff, nxt_state;
  nahif_op_t   op_ff, nxt_op;
  nahif_ck_t   ck_ff, nxt_ck;
  logic [12:0] step_ff, nxt_step, len_ff, nxt_len, col_ff, nxt_col;
  logic [16:0] row_ff, nxt_row;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [7:0]  wbyte_ff, nxt_wbyte, rd_byte_ff, nxt_rd_byte, status_ff, nxt_status;
  logic        req_ff, nxt_req, sel_ff, nxt_sel, init_ff, nxt_init, wp_n_ff, nxt_wp_n;
  logic        op_ready_ff, nxt_op_ready, op_done_ff, nxt_op_done;
  logic        wr_ready_ff, nxt_wr_ready, rd_valid_ff, nxt_rd_valid;
  logic        rb_meta_ff, rb_sync_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // first and second opcode of each operation
  function automatic logic [7:0] first_cmd(input nahif_op_t op);
    case (op)
      OP_RESET: first_cmd = OPC_RESET;
      OP_READ:  first_cmd = OPC_READ_MODE;
      OP_PROG:  first_cmd = OPC_PROG;
      default:  first_cmd = OPC_STATUS;
    endcase
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input nahif_op_t op);
    second_cmd = (op == OP_PROG) ? OPC_PROG_GO : OPC_READ_GO;
  endfunction : second_cmd

  // one address byte; undefined bits forced low
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [12:0] col,
                                           input logic [16:0] row);
    case (idx)
      3'h0:    addr_byte = col[7:0];
      3'h1:    addr_byte = {3'h0, col[12], col[12] ? 4'h0 : col[11:8]};
      3'h2:    addr_byte = row[7:0];
      3'h3:    addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction : addr_byte

  nahif_cycle u_cycle (
    .clk            (clk),
    .srst           (srst),
    .cyc            (cyc.eng),
    .io_in          (io_in),
    .io_out         (io_out),
    .io_oe_n        (io_oe_n),
    .chip_select_n  (chip_select_n),
    .cmd_latch_en   (cmd_latch_en),
    .addr_latch_en  (addr_latch_en),
    .write_strobe_n (write_strobe_n),
    .read_strobe_n  (read_strobe_n)
  );

  // sequencer: one bus cycle requested at a time, advanced on done
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_ck       = ck_ff;
    nxt_step     = step_ff;
    nxt_len      = len_ff;
    nxt_col      = col_ff;
    nxt_row      = row_ff;
    nxt_wbyte    = wbyte_ff;
    nxt_rd_byte  = rd_byte_ff;
    nxt_status   = status_ff;
    nxt_sel      = sel_ff;
    nxt_init     = init_ff;
    nxt_wp_n     = wp_n_ff;
    nxt_req      = req_ff && !cyc.done;
    nxt_cnt      = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 16'h0001;
    nxt_op_done  = 1'b0;
    nxt_wr_ready = 1'b0;
    nxt_rd_valid = 1'b0;
    case (state_ff)
      S_PWR: begin
        // power-on wait plus ready level, then a forced reset
        if ((cnt_ff >= PWR_WAIT_CNT) && rb_sync_ff) begin
          nxt_op    = OP_RESET;
          nxt_sel   = 1'b1;
          nxt_state = S_CMD1;
        end
      end
      S_IDLE: begin
        if (op_valid && op_ready_ff) begin
          nxt_op    = op_kind;
          nxt_col   = op_col;
          nxt_row   = {op_block, op_page};
          nxt_len   = op_len;
          nxt_sel   = 1'b1;
          nxt_state = (op_kind == OP_STATUS) ? S_STAT : S_CMD1;
        end else if ((wp_n_ff == protect_req) && rb_sync_ff) begin
          // protect level only moves between operations while ready
          nxt_wp_n  = !protect_req;
          nxt_cnt   = 16'h0000;
          nxt_state = S_WPSET;
        end
      end
      S_WPSET: begin
        if (cnt_ff >= SETTLE_CNT - 16'h0001) begin
          nxt_state = S_IDLE;
        end
      end
      S_CMD1: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_ck    = CK_CMD;
          nxt_wbyte = first_cmd(op_ff);
        end else if (cyc.done) begin
          nxt_state = (op_ff == OP_RESET) ? S_BUSY : S_ADDR;
          nxt_step  = 13'h0000;
          nxt_cnt   = 16'h0000;
        end
      end
      S_ADDR: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_ck    = CK_ADDR;
          nxt_wbyte = addr_byte(step_ff[2:0], col_ff, row_ff);
        end else if (cyc.done) begin
          if (step_ff[2:0] == ADDR_LAST) begin
            nxt_state = (op_ff == OP_READ) ? S_CMD2 : S_DIN;
            nxt_step  = 13'h0000;
          end else begin
            nxt_step = step_ff + 13'h0001;
          end
        end
      end
      S_DIN: begin
        // stalls on wr_valid; one byte per bus cycle
        if (!req_ff) begin
          if (wr_valid) begin
            nxt_req      = 1'b1;
            nxt_ck       = CK_DIN;
            nxt_wbyte    = wr_byte;
            nxt_wr_ready = 1'b1;
          end
        end else if (cyc.done) begin
          if (step_ff >= len_ff - 13'h0001) begin
            nxt_state = S_CMD2;
          end
          nxt_step = step_ff + 13'h0001;
        end
      end
      S_CMD2: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_ck    = CK_CMD;
          nxt_wbyte = second_cmd(op_ff);
        end else if (cyc.done) begin
          nxt_state = S_BUSY;
          nxt_cnt   = 16'h0000;
        end
      end
      S_BUSY: begin
        // let the busy level appear before trusting the ready level
        if ((cnt_ff >= BUSY_WAIT_CNT) && rb_sync_ff) begin
          nxt_step = 13'h0000;
          case (op_ff)
            OP_READ: nxt_state = S_RDMODE;
            OP_PROG: nxt_state = S_STAT;
            default: begin
              nxt_state   = S_IDLE;
              nxt_sel     = 1'b0;
              nxt_op_done = init_ff;
              nxt_init    = 1'b1;
            end
          endcase
        end
      end
      S_RDMODE: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_ck    = CK_CMD;
          nxt_wbyte = OPC_READ_MODE;
        end else if (cyc.done) begin
          nxt_state = S_DOUT;
        end
      end
      S_DOUT: begin
        if (!req_ff) begin
          nxt_req = 1'b1;
          nxt_ck  = CK_DOUT;
        end else if (cyc.done) begin
          nxt_rd_byte  = cyc.rbyte;
          nxt_rd_valid = 1'b1;
          nxt_step     = step_ff + 13'h0001;
          if (step_ff >= len_ff - 13'h0001) begin
            nxt_state   = S_IDLE;
            nxt_sel     = 1'b0;
            nxt_op_done = 1'b1;
          end
        end
      end
      S_STAT: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_ck    = CK_CMD;
          nxt_wbyte = OPC_STATUS;
        end else if (cyc.done) begin
          nxt_state = S_STATRD;
        end
      end
      S_STATRD: begin
        if (!req_ff) begin
          nxt_req = 1'b1;
          nxt_ck  = CK_DOUT;
        end else if (cyc.done) begin
          nxt_status   = cyc.rbyte;
          nxt_rd_byte  = cyc.rbyte;
          nxt_rd_valid = (op_ff == OP_STATUS);
          nxt_state    = S_IDLE;
          nxt_sel      = 1'b0;
          nxt_op_done  = 1'b1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    // ready only when idle, target ready and no protect change pending
    nxt_op_ready = (nxt_state == S_IDLE) && rb_sync_ff && (nxt_wp_n != protect_req)
                   && !(op_valid && op_ready_ff);
  end

  // protect held low through power-on; first sync flop feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff    <= S_PWR;
      op_ff       <= OP_RESET;
      ck_ff       <= CK_CMD;
      step_ff     <= 13'h0000;
      len_ff      <= 13'h0000;
      col_ff      <= 13'h0000;
      row_ff      <= 17'h0_0000;
      cnt_ff      <= 16'h0000;
      wbyte_ff    <= 8'h00;
      rd_byte_ff  <= 8'h00;
      status_ff   <= 8'h00;
      req_ff      <= 1'b0;
      sel_ff      <= 1'b0;
      init_ff     <= 1'b0;
      wp_n_ff     <= 1'b0;
      op_ready_ff <= 1'b0;
      op_done_ff  <= 1'b0;
      wr_ready_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rb_meta_ff  <= 1'b0;
      rb_sync_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      ck_ff       <= nxt_ck;
      step_ff     <= nxt_step;
      len_ff      <= nxt_len;
      col_ff      <= nxt_col;
      row_ff      <= nxt_row;
      cnt_ff      <= nxt_cnt;
      wbyte_ff    <= nxt_wbyte;
      rd_byte_ff  <= nxt_rd_byte;
      status_ff   <= nxt_status;
      req_ff      <= nxt_req;
      sel_ff      <= nxt_sel;
      init_ff     <= nxt_init;
      wp_n_ff     <= nxt_wp_n;
      op_ready_ff <= nxt_op_ready;
      op_done_ff  <= nxt_op_done;
      wr_ready_ff <= nxt_wr_ready;
      rd_valid_ff <= nxt_rd_valid;
      rb_meta_ff  <= ready_busy_n;
      rb_sync_ff  <= rb_meta_ff;
    end
  end

  assign cyc.req         = req_ff;
  assign cyc.kind        = ck_ff;
  assign cyc.wbyte       = wbyte_ff;
  assign cyc.sel         = sel_ff;
  assign wr_ready        = wr_ready_ff;
  assign rd_byte         = rd_byte_ff;
  assign rd_valid        = rd_valid_ff;
  assign op_ready        = op_ready_ff;
  assign op_done         = op_done_ff;
  assign op_status       = status_ff;
  assign write_protect_n = wp_n_ff;

  a_first_reset: assert property ($rose(req_ff) && !init_ff |-> ck_ff == CK_CMD
    && wbyte_ff == OPC_RESET) else $error("first command is not reset");
  a_pwr_wait: assert property ($past(state_ff) == S_PWR && state_ff != S_PWR |->
    $past(cnt_ff) >= PWR_WAIT_CNT && $past(rb_sync_ff)) else $error("power wait cut short");
  a_addr_top: assert property (req_ff && ck_ff == CK_ADDR && step_ff == 13'h0001 |->
    wbyte_ff[7:5] == 3'h0) else $error("second address byte top bits set");
  a_col12_zero: assert property (req_ff && ck_ff == CK_ADDR && step_ff == 13'h0001
    && wbyte_ff[4] |-> wbyte_ff[3:0] == 4'h0) else $error("column bits under bit 12 set");
  a_addr_fifth: assert property (req_ff && ck_ff == CK_ADDR && step_ff == 13'h0004 |->
    wbyte_ff[7:1] == 7'h00) else $error("fifth address byte upper bits set");
  a_addr_count: assert property ($past(state_ff) == S_ADDR && state_ff != S_ADDR |->
    $past(step_ff) == 13'h0004) else $error("wrong number of address cycles");
  a_wp_when: assert property ($changed(wp_n_ff) |-> $past(state_ff) == S_IDLE
    && $past(rb_sync_ff) && !$past(sel_ff)) else $error("protect moved during activity");
  a_wp_settle: assert property ($changed(wp_n_ff) |-> (state_ff == S_WPSET) [*4])
    else $error("protect settle wait too short");
  a_rdmode_first: assert property ($rose(state_ff == S_DOUT) |-> $past(state_ff) == S_RDMODE)
    else $error("data output without read mode");

  c_read_page: cover property ($fell(state_ff == S_DOUT) && op_done_ff);
  c_program: cover property ($fell(state_ff == S_STATRD) && op_ff == OP_PROG);
  c_wp_change: cover property ($changed(wp_n_ff));
endmodule : nahif_ctrl

// ===== tb/nahif_dev_model.sv
`timescale 1ns/1ps
// behavioural flash target on the far side of the bus
module nahif_dev_model #(
  parameter int PWR_CYC = 100,
  parameter int RST_CYC = 40,
  parameter int RD_CYC  = 20,
  parameter int PG_CYC  = 30
) (
  input  wire logic       clk,
  input  wire logic       chip_select_n,
  input  wire logic       cmd_latch_en,
  input  wire logic       addr_latch_en,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_protect_n,
  input  wire logic       host_oe_n,
  input  wire logic [7:0] host_out,
  output logic      [7:0] io_wire,
  output logic            ready_busy_n,
  output int              viol
);
  logic [7:0] mem [int];
  logic [7:0] pend [int];
  logic [7:0] a [5];
  logic [7:0] dq = 8'h00;
  logic [7:0] lastv = 8'h00;
  logic       stat = 1'b0;
  logic       fail = 1'b0;
  int         cyc = 0;
  int         busy_to = PWR_CYC;
  int         acnt = 0;
  int         col = 0;
  int         row = 0;
  int         ncmd = 0;
  wire        busy = cyc < busy_to;
  wire        out_md = !chip_select_n && !cmd_latch_en && !addr_latch_en && write_strobe_n;
  wire        dev_oe = out_md && !read_strobe_n;
  initial viol = 0;
  // pull-up on the open-drain line; a released data bus shows the inverse of its last value
  assign ready_busy_n = busy ? 1'b0 : 1'b1;
  assign io_wire = !host_oe_n ? host_out : dev_oe ? dq : ~lastv;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!host_oe_n || dev_oe) lastv <= io_wire;
  end
  // command decode; only status read passes a busy die
  task do_cmd(input logic [7:0] c);
    if (ncmd == 0 && c !== 8'hff) viol++;
    ncmd++;
    if (busy && c !== 8'h70) return;
    case (c)
      8'hff: begin busy_to = cyc + RST_CYC; stat = 0; fail = 0; end
      8'h70: stat = 1;
      8'h00: begin stat = 0; acnt = 0; end
      8'h80: begin acnt = 0; fail = 0; pend.delete(); end
      8'h30: begin if (acnt != 5) viol++; busy_to = cyc + RD_CYC; end
      8'h10: begin
        if (acnt != 5) viol++;
        if (write_protect_n) begin
          foreach (pend[k]) mem[k] = pend[k];
          busy_to = cyc + PG_CYC;
        end else fail = 1;
      end
      default: ;
    endcase
  endtask : do_cmd
  // write strobe capture; deselected or mixed latches change nothing
  always @(posedge write_strobe_n) if (!chip_select_n && read_strobe_n) begin
    if (cmd_latch_en && !addr_latch_en) do_cmd(io_wire);
    else if (addr_latch_en && !cmd_latch_en && !busy && acnt < 5) begin
      a[acnt] = io_wire;
      acnt++;
      if (acnt == 5) begin
        col = {a[1][4:0], a[0]};
        row = {a[4][0], a[3], a[2]};
        if (a[1][7:5] != 0 || a[4][7:1] != 0 || (a[1][4] && a[1][3:0] != 0)) viol++;
      end
    end else if (!cmd_latch_en && !addr_latch_en && !busy) begin
      pend[row * 8192 + col] = io_wire;
      col++;
    end
  end
  // data out per falling read strobe; erased bytes read as ff
  always @(negedge read_strobe_n) if (out_md) begin
    if (stat) dq = {write_protect_n, !busy, 5'h00, fail};
    else if (!busy) begin
      dq = mem.exists(row * 8192 + col) ? mem[row * 8192 + col] : 8'hff;
      col++;
    end
  end
endmodule : nahif_dev_model

// ===== tb/test_nahif_ctrl.sv
`timescale 1ns/1ps
module test_nahif_ctrl;
  import nahif_pkg::*;
  logic        clk = 0, srst, op_valid, protect_req, wr_valid;
  nahif_op_t   op_kind;
  logic [12:0] op_col, op_len, col;
  logic [5:0]  op_page, pg;
  logic [10:0] op_block, bk;
  logic [7:0]  wr_byte, rd_byte, op_status, io_out, io_in;
  logic        wr_ready, rd_valid, op_ready, op_done, io_oe_n, chip_select_n, cmd_latch_en;
  logic        addr_latch_en, write_strobe_n, read_strobe_n, write_protect_n, ready_busy_n;
  int          viol, error_cnt = 0, comparisons = 0, cycles = 0;
  logic [7:0]  rd_q [$], wq [$], d [4];
  logic [8:0]  done_q [$];
  logic [7:0]  e;
  logic [8:0]  q;

  always #12.5 clk = ~clk;

  nahif_ctrl dut (.clk, .srst, .op_valid, .op_kind, .op_col, .op_page, .op_block, .op_len,
    .protect_req, .wr_byte, .wr_valid, .wr_ready, .rd_byte, .rd_valid, .op_ready, .op_done,
    .op_status, .io_in, .io_out, .io_oe_n, .chip_select_n, .cmd_latch_en, .addr_latch_en,
    .write_strobe_n, .read_strobe_n, .write_protect_n, .ready_busy_n);
  nahif_dev_model dev (.clk, .chip_select_n, .cmd_latch_en, .addr_latch_en, .write_strobe_n,
    .read_strobe_n, .write_protect_n, .host_oe_n(io_oe_n), .host_out(io_out),
    .io_wire(io_in), .ready_busy_n, .viol);

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // one request, program bytes from wq, then wait for completion
  task do_op(input nahif_op_t k, input logic [12:0] c, input logic [5:0] p,
             input logic [10:0] b, input logic [12:0] len);
    int n;
    n = 0;
    @(negedge clk);
    // power-on wait alone is about 4000 cycles, so this limit must exceed it
    while (op_ready !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk("op_ready", 1, op_ready);
    op_kind  = k;
    op_col   = c;
    op_page  = p;
    op_block = b;
    op_len   = len;
    op_valid = 1;
    @(negedge clk);
    op_valid = 0;
    for (int i = 0; k == OP_PROG && i < len; i++) begin
      wr_byte  = wq[i];
      wr_valid = 1;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (wr_ready !== 1'b1 && n < 500);
      chk("wr_ready", 1, wr_ready);
      @(negedge clk);
    end
    wr_valid = 0;
    n = 0;
    while (op_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op_done", 1, op_done);
  endtask : do_op

  // monitor: every result pops the oldest expectation
  always begin
    @(posedge clk);
    #1;
    if (rd_valid === 1'b1) begin
      e = rd_q.size() ? rd_q.pop_front() : 8'hxx;
      chk("rd_byte", e, rd_byte);
    end
    if (op_done === 1'b1) begin
      q = done_q.size() ? done_q.pop_front() : 9'h1xx;
      if (q[8]) chk("op_status", q[7:0], op_status);
    end
  end

  // hang guard sized well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("[ERR] timeout exp done got hang");
      finish_test();
    end
  end

  initial begin
    // idle levels while reset is held
    srst        = 1;
    op_valid    = 0;
    protect_req = 0;
    wr_valid    = 0;
    op_kind     = OP_STATUS;
    op_col      = 13'h0000;
    op_len      = 13'h0001;
    op_page     = 6'h00;
    op_block    = 11'h000;
    wr_byte     = 8'h00;
    void'($urandom(32'hdf00_9adf));
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 0;
    rd_q.push_back(8'hc0);
    done_q.push_back(9'h1c0);
    do_op(OP_STATUS, 13'h0000, 6'h00, 11'h000, 13'h0001);
    col = {1'b1, 4'h0, 8'($urandom)};
    pg = 6'($urandom);
    bk = 11'($urandom);
    for (int i = 0; i < 4; i++) d[i] = 8'($urandom);
    wq = '{d[0], d[1], d[2], d[3]};
    done_q.push_back(9'h1c0);
    do_op(OP_PROG, col, pg, bk, 13'h0004);
    rd_q = '{d[0], d[1], d[2], d[3], 8'hff};
    done_q.push_back(9'h000);
    do_op(OP_READ, col, pg, bk, 13'h0005);
    rd_q = '{8'hff, 8'hff};
    done_q.push_back(9'h000);
    do_op(OP_READ, col, pg, bk ^ 11'h400, 13'h0002);
    @(negedge clk);
    protect_req = 1;
    wq = '{~d[0], ~d[1], ~d[2], ~d[3]};
    done_q.push_back(9'h141);
    do_op(OP_PROG, col, pg, bk, 13'h0004);
    chk("write_protect_n", 0, write_protect_n);
    rd_q = '{d[0], d[1], d[2], d[3]};
    done_q.push_back(9'h000);
    do_op(OP_READ, col, pg, bk, 13'h0004);
    done_q.push_back(9'h000);
    do_op(OP_RESET, 13'h0000, 6'h00, 11'h000, 13'h0001);
    rd_q.push_back(8'h40);
    done_q.push_back(9'h140);
    do_op(OP_STATUS, 13'h0000, 6'h00, 11'h000, 13'h0001);
    repeat (4) @(posedge clk);
    chk("model_violations", 0, viol);
    chk("left_expected", 0, rd_q.size() + done_q.size());
    finish_test();
  end
endmodule : test_nahif_ctrl
